/* File: core/wor_option_reg.sv */
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module wor_option_reg #(
  parameter int WAKE_SHORT = wor_pkg::WOR_WAKE_SHORT,
  parameter int WAKE_LONG = wor_pkg::WOR_WAKE_LONG,
  parameter int WDOG_SHORT = wor_pkg::WOR_WDOG_SHORT,
  parameter int WDOG_LONG = wor_pkg::WOR_WDOG_LONG
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Reset sources
  input wire logic lviReset,
  input wire logic otherReset,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Divided oscillator clock enable
  input wire logic divClkTick,
  // Detector controls
  output logic regDetectorEnable,
  output logic supplyDetectorEnable,
  output logic tripHighSelect,
  // Serial bus reset routing
  input wire logic busResetSeen,
  output logic busIrqReq,
  output logic chipResetReq,
  // Halt mode
  input wire logic haltOpcodeSeen,
  output logic haltAccept,
  output logic illegalOpcode,
  input wire logic wakeRequest,
  input wire logic wakeByPin,
  output logic haltExit,
  // Watchdog
  input wire logic watchdogFeed,
  output logic watchdogResetReq
);
  import wor_pkg::*;

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (WAKE_SHORT < 1 || WAKE_LONG < 1 || WDOG_SHORT < 1 || WDOG_LONG < 1) begin : g_chk_min
    $error("timer counts must be at least one");
  end
  if (WAKE_LONG >= (1 << WOR_TIMER_W) || WDOG_LONG >= (1 << WOR_TIMER_W)) begin : g_chk_max
    $error("timer count exceeds counter width");
  end

  localparam logic [WOR_TIMER_W-1:0] WAKE_SHORT_C = WOR_TIMER_W'(WAKE_SHORT);
  localparam logic [WOR_TIMER_W-1:0] WAKE_LONG_C = WOR_TIMER_W'(WAKE_LONG);
  localparam logic [WOR_TIMER_W-1:0] WDOG_SHORT_C = WOR_TIMER_W'(WDOG_SHORT);
  localparam logic [WOR_TIMER_W-1:0] WDOG_LONG_C = WOR_TIMER_W'(WDOG_LONG);

  logic [7:0] option_r;
  logic writeDone_r;
  logic hitOption;
  logic accessPhase;
  logic writeAccept;
  logic [WOR_TIMER_W-1:0] wakeLimit_r;
  logic halted_r;

  // ------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------
  assign hitOption = (paddr == WOR_OPT_ADDR);
  assign accessPhase = psel && penable;
  assign writeAccept = accessPhase && pwrite && hitOption && !writeDone_r;
  assign pready = 1'b1;
  assign pslverr = accessPhase && !hitOption;

  // Read data, valid any time
  always_comb begin
    prdata = 32'h0;
    if (psel && !pwrite && hitOption) begin
      prdata = {24'h0, option_r};
    end
  end

  // ------------------------------------------------------------
  // Upper nibble: power-on and undervoltage reset only
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      option_r[7:4] <= WOR_OPT_RESET[7:4];
    end else if (lviReset) begin
      option_r[7:4] <= WOR_OPT_RESET[7:4];
    end else if (writeAccept && !otherReset) begin
      option_r[7:4] <= pwdata[7:4];
    end
  end

  // Lower nibble: every reset source
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      option_r[3:0] <= WOR_OPT_RESET[3:0];
    end else if (lviReset || otherReset) begin
      option_r[3:0] <= WOR_OPT_RESET[3:0];
    end else if (writeAccept) begin
      option_r[3:0] <= pwdata[3:0];
    end
  end

  // Write-once lock, re-armed by every reset
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      writeDone_r <= 1'b0;
    end else if (lviReset || otherReset) begin
      writeDone_r <= 1'b0;
    end else if (writeAccept) begin
      writeDone_r <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Static field levels
  // ------------------------------------------------------------
  assign regDetectorEnable = !option_r[WOR_BIT_REG_DET_DIS];
  assign tripHighSelect = option_r[WOR_BIT_TRIP_SEL];
  assign supplyDetectorEnable = !option_r[WOR_BIT_SUP_DET_DIS];

  // ------------------------------------------------------------
  // Serial bus reset routing and halt opcode check
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      busIrqReq <= 1'b0;
      chipResetReq <= 1'b0;
    end else begin
      busIrqReq <= busResetSeen && option_r[WOR_BIT_BUS_RST_DIS];
      chipResetReq <= busResetSeen && !option_r[WOR_BIT_BUS_RST_DIS];
    end
  end

  // Halt opcode accepted or flagged illegal
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      haltAccept <= 1'b0;
      illegalOpcode <= 1'b0;
    end else begin
      haltAccept <= haltOpcodeSeen && option_r[WOR_BIT_HALT_EN];
      illegalOpcode <= haltOpcodeSeen && !option_r[WOR_BIT_HALT_EN];
    end
  end

  // ------------------------------------------------------------
  // Halt wake delay
  // ------------------------------------------------------------
  wor_timer_if #(.W(WOR_TIMER_W)) wakeIf ();
  logic wakeStart;

  assign wakeStart = halted_r && !wakeIf.busy && (wakeRequest || wakeByPin);

  // Halted state, entered on accepted halt, left when delay ends
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      halted_r <= 1'b0;
    end else if (haltAccept) begin
      halted_r <= 1'b1;
    end else if (wakeIf.done) begin
      halted_r <= 1'b0;
    end
  end

  // Delay chosen when the wake starts
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wakeLimit_r <= WAKE_LONG_C;
    end else if (wakeStart) begin
      if (wakeByPin || !option_r[WOR_BIT_SHORT_WAKE]) begin
        wakeLimit_r <= WAKE_LONG_C;
      end else begin
        wakeLimit_r <= WAKE_SHORT_C;
      end
    end
  end

  // Start one cycle after the limit is latched
  logic wakeStartD_r;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      wakeStartD_r <= 1'b0;
    end else begin
      wakeStartD_r <= wakeStart;
    end
  end

  assign wakeIf.start = wakeStartD_r;
  assign wakeIf.abort = 1'b0;
  assign wakeIf.limit = wakeLimit_r;
  assign haltExit = wakeIf.done;

  wor_cycle_timer #(.W(WOR_TIMER_W)) wakeTimer (
    .clock(clock),
    .reset_n(reset_n),
    .tick(divClkTick),
    .ctl(wakeIf)
  );

  // ------------------------------------------------------------
  // Watchdog
  // ------------------------------------------------------------
  wor_timer_if #(.W(WOR_TIMER_W)) wdogIf ();
  logic wdogOff;

  assign wdogOff = option_r[WOR_BIT_WDOG_DIS];
  assign wdogIf.abort = wdogOff;
  assign wdogIf.start = !wdogOff && (watchdogFeed || !wdogIf.busy);
  assign wdogIf.limit = option_r[WOR_BIT_WDOG_RATE] ? WDOG_SHORT_C : WDOG_LONG_C;
  assign watchdogResetReq = wdogIf.done;

  wor_cycle_timer #(.W(WOR_TIMER_W)) wdogTimer (
    .clock(clock),
    .reset_n(reset_n),
    .tick(divClkTick),
    .ctl(wdogIf)
  );

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  property p_frozen_after_write;
    @(posedge clock) disable iff (!reset_n)
    writeDone_r && !lviReset && !otherReset |=> $stable(option_r);
  endproperty
  a_frozen_after_write: assert property (p_frozen_after_write) else $error("option changed after lock");

  property p_write_takes_data;
    @(posedge clock) disable iff (!reset_n)
    accessPhase && pwrite && hitOption && !writeDone_r && !lviReset && !otherReset
      |=> option_r == $past(pwdata[7:0]) && writeDone_r;
  endproperty
  a_write_takes_data: assert property (p_write_takes_data) else $error("first write not stored");

  property p_read_anytime;
    @(posedge clock) disable iff (!reset_n)
    psel && !pwrite && hitOption |-> prdata == {24'h0, option_r};
  endproperty
  a_read_anytime: assert property (p_read_anytime) else $error("read data wrong");

  property p_other_reset_keeps_upper;
    @(posedge clock) disable iff (!reset_n)
    otherReset && !lviReset |=> option_r[7:4] == $past(option_r[7:4]) && option_r[3:0] == 4'h0 && !writeDone_r;
  endproperty
  a_other_reset_keeps_upper: assert property (p_other_reset_keeps_upper) else $error("other reset wrong");

  property p_lvi_clears_all;
    @(posedge clock) disable iff (!reset_n)
    lviReset |=> option_r == WOR_OPT_RESET && !writeDone_r;
  endproperty
  a_lvi_clears_all: assert property (p_lvi_clears_all) else $error("undervoltage reset did not clear");

  property p_bus_reset_route;
    @(posedge clock) disable iff (!reset_n)
    busResetSeen |=> (busIrqReq == $past(option_r[WOR_BIT_BUS_RST_DIS])) && (chipResetReq != busIrqReq);
  endproperty
  a_bus_reset_route: assert property (p_bus_reset_route) else $error("bus reset misrouted");

  property p_halt_illegal;
    @(posedge clock) disable iff (!reset_n)
    haltOpcodeSeen && !option_r[WOR_BIT_HALT_EN] |=> illegalOpcode && !haltAccept;
  endproperty
  a_halt_illegal: assert property (p_halt_illegal) else $error("halt opcode not refused");

  property p_pin_wake_long;
    @(posedge clock) disable iff (!reset_n)
    wakeStart && wakeByPin |=> wakeLimit_r == WAKE_LONG_C;
  endproperty
  a_pin_wake_long: assert property (p_pin_wake_long) else $error("pin wake not long");

  property p_short_wake;
    @(posedge clock) disable iff (!reset_n)
    wakeStart && !wakeByPin && option_r[WOR_BIT_SHORT_WAKE] |=> wakeLimit_r == WAKE_SHORT_C;
  endproperty
  a_short_wake: assert property (p_short_wake) else $error("short wake not chosen");

  property p_wdog_off;
    @(posedge clock) disable iff (!reset_n)
    wdogOff ##1 wdogOff |-> !watchdogResetReq && !wdogIf.busy;
  endproperty
  a_wdog_off: assert property (p_wdog_off) else $error("watchdog ran while disabled");

  property p_detectors;
    @(posedge clock) disable iff (!reset_n)
    regDetectorEnable != option_r[7] && supplyDetectorEnable != option_r[4] && tripHighSelect == option_r[6];
  endproperty
  a_detectors: assert property (p_detectors) else $error("detector levels wrong");

  property p_wdog_rate;
    @(posedge clock) disable iff (!reset_n)
    option_r[WOR_BIT_WDOG_RATE] |-> wdogIf.limit == WDOG_SHORT_C;
  endproperty
  a_wdog_rate: assert property (p_wdog_rate) else $error("watchdog rate wrong");

  c_write: cover property (@(posedge clock) disable iff (!reset_n) writeAccept);
  c_second_write: cover property (@(posedge clock) disable iff (!reset_n)
    accessPhase && pwrite && hitOption && writeDone_r);
  c_halt_exit: cover property (@(posedge clock) disable iff (!reset_n) haltExit);
  c_wdog_fire: cover property (@(posedge clock) disable iff (!reset_n) watchdogResetReq);
endmodule

/* File: core/wor_pkg.sv */
package wor_pkg;
  // ------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------
  localparam logic [7:0] WOR_OPT_INDEX = 8'h1f;
  localparam logic [11:0] WOR_OPT_ADDR = {2'h0, WOR_OPT_INDEX, 2'h0};
  localparam logic [7:0] WOR_OPT_RESET = 8'h00;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int WOR_BIT_REG_DET_DIS = 7;
  localparam int WOR_BIT_TRIP_SEL = 6;
  localparam int WOR_BIT_BUS_RST_DIS = 5;
  localparam int WOR_BIT_SUP_DET_DIS = 4;
  localparam int WOR_BIT_SHORT_WAKE = 3;
  localparam int WOR_BIT_WDOG_RATE = 2;
  localparam int WOR_BIT_HALT_EN = 1;
  localparam int WOR_BIT_WDOG_DIS = 0;

  // ------------------------------------------------------------
  // Timing counts in divided oscillator cycles
  // ------------------------------------------------------------
  localparam int WOR_TIMER_W = 18;
  localparam int WOR_WAKE_SHORT = 2048;
  localparam int WOR_WAKE_LONG = 4096;
  localparam int WOR_WDOG_SHORT = (1 << 13) - (1 << 4);
  localparam int WOR_WDOG_LONG = (1 << 18) - (1 << 4);
endpackage

/* File: core/wor_timer_if.sv */
`timescale 1ns/1ps
interface wor_timer_if #(parameter int W = 18);
  logic start;
  logic abort;
  logic [W-1:0] limit;
  logic busy;
  logic done;

  modport owner (output start, output abort, output limit, input busy, input done);
  modport timer (input start, input abort, input limit, output busy, output done);
endinterface

/* File: core/wor_cycle_timer.sv */
`timescale 1ns/1ps
module wor_cycle_timer #(
  parameter int W = 18
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Divided oscillator tick
  input wire logic tick,
  // Control from owner
  wor_timer_if.timer ctl
);
  logic [W-1:0] count_r;
  logic run_r;
  logic done_r;

  // ------------------------------------------------------------
  // Tick counter, done pulses after limit ticks
  // ------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      count_r <= '0;
      run_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (ctl.abort) begin
        run_r <= 1'b0;
        count_r <= '0;
      end else if (ctl.start) begin
        run_r <= 1'b1;
        count_r <= '0;
      end else if (run_r && tick) begin
        if (count_r >= ctl.limit - W'(1)) begin // Also ends a count that a lowered limit has passed
          run_r <= 1'b0;
          done_r <= 1'b1;
        end else begin
          count_r <= count_r + W'(1);
        end
      end
    end
  end

  assign ctl.busy = run_r;
  assign ctl.done = done_r;
endmodule

/* File: sim/tb.sv */
`timescale 1ns/1ps
module tb;
  import wor_pkg::*;
  localparam int WS = 4;
  localparam int WL = 8;
  localparam int DS = 6;
  localparam int DL = 20;
  logic clock = 1'b0, reset_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, divClkTick = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rdat;
  logic [6:0] pin = 7'h00;
  logic rerr;
  wire [31:0] prdata;
  wire pready, pslverr, regDetectorEnable, supplyDetectorEnable, tripHighSelect, busIrqReq, chipResetReq;
  wire haltAccept, illegalOpcode, haltExit, watchdogResetReq;
  int nErrors = 0;
  int samplesChecked = 0;
  int n;

  // ----------------------------------------
  // Clock, tick and device
  // ----------------------------------------
  always #4 clock = ~clock;
  // Divided clock enable, one cycle in two
  always @(posedge clock) divClkTick <= ~divClkTick;
  wor_option_reg #(.WAKE_SHORT(WS), .WAKE_LONG(WL), .WDOG_SHORT(DS), .WDOG_LONG(DL)) u_wor_option_reg (
    .clock(clock), .reset_n(reset_n), .lviReset(pin[6]), .otherReset(pin[5]),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .divClkTick(divClkTick),
    .regDetectorEnable(regDetectorEnable), .supplyDetectorEnable(supplyDetectorEnable),
    .tripHighSelect(tripHighSelect), .busResetSeen(pin[0]), .busIrqReq(busIrqReq),
    .chipResetReq(chipResetReq), .haltOpcodeSeen(pin[1]), .haltAccept(haltAccept),
    .illegalOpcode(illegalOpcode), .wakeRequest(pin[2]), .wakeByPin(pin[3]), .haltExit(haltExit),
    .watchdogFeed(pin[4]), .watchdogResetReq(watchdogResetReq));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      nErrors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    // Wait for the answer, ends as soon as pready is seen high
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rdat = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Pulse one event input for a cycle, look at the edge after
  task automatic fire(input int i);
    @(posedge clock);
    pin[i] <= 1'b1;
    @(posedge clock);
    pin <= 7'h00;
    @(negedge clock);
  endtask

  // Ticks counted until the selected strobe shows, -1 if it never does
  task automatic count_ticks(input bit wd, output int c);
    int k;
    c = 0;
    for (k = 0; k < 200; k++) begin
      @(posedge clock);
      if (divClkTick === 1'b1) c++;
      @(negedge clock);
      if ((wd ? watchdogResetReq : haltExit) === 1'b1) return;
    end
    c = -1;
  endtask

  task automatic opt_check(input logic [7:0] v);
    apb(1'b0, WOR_OPT_ADDR, 32'h0);
    check(rdat, {24'h0, v});
    check({31'h0, rerr}, 32'h0);
    @(negedge clock);
    check({29'h0, regDetectorEnable, supplyDetectorEnable, tripHighSelect}, {29'h0, ~v[7], ~v[4], v[6]});
  endtask

  task automatic wake(input int i, input int exp);
    fire(1);
    check({30'h0, haltAccept, illegalOpcode}, 32'h2);
    fire(i);
    @(posedge clock);
    count_ticks(1'b0, n);
    check(n, exp);
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    opt_check(8'h00);
    apb(1'b0, 12'h080, 32'h0);
    check({rdat[30:0], rerr}, 32'h1);
    check({31'h0, pready}, 32'h1);
  endtask

  task automatic t_lock;
    apb(1'b1, 12'h080, 32'hff);
    apb(1'b1, WOR_OPT_ADDR, 32'hee);
    opt_check(8'hee);
    apb(1'b1, WOR_OPT_ADDR, 32'h11);
    check({31'h0, rerr}, 32'h0);
    opt_check(8'hee);
    fire(0);
    check({30'h0, busIrqReq, chipResetReq}, 32'h2);
    wake(2, WS);
    wake(3, WL);
    count_ticks(1'b1, n);
    count_ticks(1'b1, n);
    check(n, DS);
  endtask

  task automatic t_partial;
    fire(5);
    opt_check(8'he0);
    apb(1'b1, WOR_OPT_ADDR, 32'h01);
    opt_check(8'h01);
    fire(0);
    check({30'h0, busIrqReq, chipResetReq}, 32'h1);
    fire(1);
    check({30'h0, haltAccept, illegalOpcode}, 32'h1);
    count_ticks(1'b1, n);
    check(n, -1);
  endtask

  task automatic t_lvi;
    fire(5);
    apb(1'b1, WOR_OPT_ADDR, 32'h90);
    fire(6);
    opt_check(8'h00);
    apb(1'b1, WOR_OPT_ADDR, 32'h12);
    opt_check(8'h12);
    wake(2, WL);
    count_ticks(1'b1, n);
    count_ticks(1'b1, n);
    check(n, DL);
    // A feed restarts the full timeout
    fire(4);
    count_ticks(1'b1, n);
    check(n, DL);
  endtask

  // ----------------------------------------
  // Verdict and run control
  // ----------------------------------------
  task automatic summarize;
    if (nErrors == 0 && samplesChecked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clock);
    reset_n <= 1'b1;
    t_reset();
    t_lock();
    t_partial();
    t_lvi();
    summarize();
  end

  // Hang guard, far beyond the few hundred cycles the run needs
  initial begin
    #200000;
    nErrors++;
    summarize();
  end
endmodule
